// ### hdl/edge_event_pkg.sv
// How it works
// RL1: nineteen edge lines, each can raise an interrupt or an event request
// RL2: per line, rising, falling or both edges selected by software
// RL3: per line mask; a masked line forwards nothing, others unaffected
// RL4: per line pending bit set on the selected edge, readable
// RL5: edges caught asynchronously, so pulses shorter than a clock count
// RL6: each of sixteen external lines picks its pin from one of seven ports
// RL7: supply level detector interrupts on falling, rising or both
// RL8: supply level detector line stays silent until software enables it
// RL9: sources are sixteen pin lines, supply detector, clock alarm and a spare aux source
// RL10: any enabled line seeing its edge raises a stop-mode wakeup
// RL11: pending bit cleared only by writing one; zero leaves it
// RL12: interrupt request is high while pending and unmasked
`default_nettype none
package edge_event_pkg;

	// ****************************************************************
	// line counts and positions
	// ****************************************************************
	localparam int NUM_LINES  = 19;
	localparam int NUM_EXT    = 16;
	localparam int NUM_PINS   = 112;
	localparam int NUM_PORTS  = NUM_PINS / NUM_EXT;
	localparam int PORT_SEL_W = 3;
	localparam int LINE_SLD   = 16;
	localparam int LINE_RTC   = 17;
	localparam int LINE_AUX   = 18;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [NUM_LINES-1:0] LINES_RST = 19'h00000;
	localparam logic [1:0]           PAIR_RST  = 2'h0;
	localparam logic                 BIT_RST   = 1'h0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef logic [NUM_LINES-1:0] line_vec_t;
	typedef logic [NUM_EXT-1:0][PORT_SEL_W-1:0] port_sel_t;

	typedef struct packed {
		line_vec_t rise_en;
		line_vec_t fall_en;
		line_vec_t irq_unmask;
		line_vec_t evt_unmask;
	} line_cfg_s;

endpackage : edge_event_pkg
`default_nettype wire

// ### hdl/edge_capture.sv
`timescale 1ns/1ps
`default_nettype none
module edge_capture (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic line_in,
	output logic      rise_evt,
	output logic      fall_evt
);
	import edge_event_pkg::*;

	logic       rise_tog;
	logic       fall_tog;
	logic       next_rise_tog;
	logic       next_fall_tog;
	logic [1:0] s1;
	logic [1:0] s2;
	logic [1:0] prev;
	logic [1:0] next_s1;
	logic [1:0] next_s2;
	logic [1:0] next_prev;
	logic [1:0] next_evt;

	// ****************************************************************
	// asynchronous capture: the line itself clocks a toggle
	// ****************************************************************
	// each edge flips its toggle, however short the pulse
	always_comb begin
		next_rise_tog = ~rise_tog;
		next_fall_tog = ~fall_tog;
	end

	always_ff @(posedge line_in or negedge rst_n) begin
		if (!rst_n) begin
			rise_tog <= BIT_RST;
		end else begin
			rise_tog <= next_rise_tog; // RL5
		end
	end

	always_ff @(negedge line_in or negedge rst_n) begin
		if (!rst_n) begin
			fall_tog <= BIT_RST;
		end else begin
			fall_tog <= next_fall_tog; // RL5
		end
	end

	// ****************************************************************
	// toggle crossing into mclk
	// ****************************************************************
	// two-stage sync, then a change of the toggle is one edge
	always_comb begin
		next_s1   = {fall_tog, rise_tog};
		next_s2   = s1;
		next_prev = s2;
		next_evt  = s2 ^ prev; // RL5
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1       <= PAIR_RST;
			s2       <= PAIR_RST;
			prev     <= PAIR_RST;
			rise_evt <= BIT_RST;
			fall_evt <= BIT_RST;
		end else begin
			s1       <= next_s1;
			s2       <= next_s2;
			prev     <= next_prev;
			rise_evt <= next_evt[0];
			fall_evt <= next_evt[1];
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_edge_capture: assert property (@(posedge mclk) disable iff (!rst_n)
		(s2[0] != prev[0]) |=> rise_evt) // RL5
		else $error("synchronised rising toggle gave no event");

endmodule : edge_capture
`default_nettype wire

// ### hdl/edge_event_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ext_edge_event_ctrl (
	input  wire logic                            mclk,
	input  wire logic                            rst_n,
	input  wire logic [edge_event_pkg::NUM_PINS-1:0] pin_in,
	input  wire edge_event_pkg::port_sel_t       port_sel,
	input  wire logic                            sld_out,
	input  wire logic                            sld_en,
	input  wire logic                            rtc_alarm,
	input  wire logic                            aux_event,
	input  wire edge_event_pkg::line_cfg_s       cfg,
	input  wire edge_event_pkg::line_vec_t       pend_clr,
	output edge_event_pkg::line_vec_t            pend,
	output edge_event_pkg::line_vec_t            irq_req,
	output edge_event_pkg::line_vec_t            evt_req,
	output logic                                 wakeup
);
	import edge_event_pkg::*;

	wire line_vec_t src;
	line_vec_t      rise_ev;
	line_vec_t      fall_ev;
	line_vec_t      trig;
	line_vec_t      irq_unmask;
	line_vec_t      evt_unmask;
	line_vec_t      next_pend;
	line_vec_t      next_irq;
	line_vec_t      next_evt;
	logic           next_wake;

	assign irq_unmask = cfg.irq_unmask;
	assign evt_unmask = cfg.evt_unmask;

	// ****************************************************************
	// line sources and edge capture
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_line
			if (g < NUM_EXT) begin : g_pin
				logic pick;
				// pin selector: line g takes bit g of the chosen port
				always_comb begin
					pick = 1'b0;
					for (int p = 0; p < NUM_PORTS; p++) begin
						if (port_sel[g] == PORT_SEL_W'(p)) begin
							pick = pin_in[p*NUM_EXT+g]; // RL6
						end
					end
				end
				assign src[g] = pick; // RL6
			end else if (g == LINE_SLD) begin : g_sld
				assign src[g] = sld_out; // RL9
			end else if (g == LINE_RTC) begin : g_rtc
				assign src[g] = rtc_alarm; // RL9
			end else begin : g_aux
				assign src[g] = aux_event;
			end

			// one capture cell per line, clocked by the line itself
			edge_capture u_cap (
				.mclk     (mclk),
				.rst_n    (rst_n),
				.line_in  (src[g]),
				.rise_evt (rise_ev[g]),
				.fall_evt (fall_ev[g])
			);
		end
	endgenerate

	// ****************************************************************
	// trigger select, pending, requests
	// ****************************************************************
	// edge choice per line; the supply line counts only when enabled
	always_comb begin
		trig = (rise_ev & cfg.rise_en) | (fall_ev & cfg.fall_en); // RL2 RL7
		if (!sld_en) begin
			trig[LINE_SLD] = 1'b0; // RL8
		end
	end

	// pending next value: a same-cycle edge beats the clear
	always_comb begin
		next_pend = (pend & ~pend_clr) | trig; // RL4 RL11
	end

	// pending register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= LINES_RST;
		end else begin
			pend <= next_pend;
		end
	end

	// interrupt follows pending; event and wakeup are one-cycle pulses
	always_comb begin
		next_irq  = next_pend & irq_unmask; // RL3 RL12
		next_evt  = trig & evt_unmask; // RL1 RL3
		next_wake = |(trig & (irq_unmask | evt_unmask)); // RL10
	end

	// request registers, so every output leaves a flip-flop
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req <= LINES_RST;
			evt_req <= LINES_RST;
			wakeup  <= BIT_RST;
		end else begin
			irq_req <= next_irq;
			evt_req <= next_evt;
			wakeup  <= next_wake;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	// every check runs on mclk and sleeps through reset
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// each trigger lands in pending one edge later
	a_pend_set: assert property ( // RL4
		(|trig) |=> ((pend & $past(trig)) == $past(trig)))
		else $error("selected edge did not set pending");

	// a pending bit may only drop where a clear was presented
	a_pend_hold: assert property ( // RL11
		##1 (($past(pend) & ~$past(pend_clr) & ~pend) == LINES_RST))
		else $error("pending bit dropped without a clear");

	// a pending bit may only rise where a trigger was seen
	a_pend_cause: assert property ( // RL4
		##1 ((pend & ~$past(pend) & ~$past(trig)) == LINES_RST))
		else $error("pending bit rose with no edge");

	// a clear with no same-cycle edge empties the bit
	a_pend_clr: assert property ( // RL11
		##1 ((pend & $past(pend_clr) & ~$past(trig)) == LINES_RST))
		else $error("cleared pending bit stayed set");

	// a masked line never shows an interrupt request
	a_irq_masked: assert property ( // RL3
		##1 ((irq_req & ~$past(irq_unmask)) == LINES_RST))
		else $error("masked line raised interrupt");

	// request is exactly pending and last cycle's mask
	a_irq_level: assert property ( // RL12
		##1 (irq_req == (pend & $past(irq_unmask))))
		else $error("interrupt does not follow pending and mask");

	// no trigger on a line with both edge kinds off
	a_trig_sel: assert property ( // RL2
		(trig & ~(cfg.rise_en | cfg.fall_en)) == LINES_RST)
		else $error("trigger on line with no edge enabled");

	// an enabled supply detector passes a selected rising edge on
	a_sld_pass: assert property ( // RL7
		(sld_en && rise_ev[LINE_SLD] && cfg.rise_en[LINE_SLD])
		|-> trig[LINE_SLD])
		else $error("enabled supply detector edge was lost");

	// disabled supply detector never sets its pending bit
	a_sld_gate: assert property ( // RL8
		(!sld_en && !pend[LINE_SLD]) |=> !pend[LINE_SLD])
		else $error("disabled supply detector set pending");

	// an edge on an enabled line raises wakeup one edge later
	a_wake_raise: assert property ( // RL10
		(|(trig & (irq_unmask | evt_unmask))) |=> wakeup)
		else $error("enabled edge gave no wakeup");

	// and nothing else raises it
	a_wake_quiet: assert property ( // RL10
		!(|(trig & (irq_unmask | evt_unmask))) |=> !wakeup)
		else $error("wakeup with no enabled edge");

	// an unmasked edge gives an event request
	a_evt_follow: assert property ( // RL1
		(|(trig & evt_unmask)) |=> (|evt_req))
		else $error("unmasked edge gave no event request");

	// one event pulse per edge, on unmasked lines only
	a_evt_exact: assert property ( // RL3
		##1 (evt_req == ($past(trig) & $past(evt_unmask))))
		else $error("event request not one pulse per edge");

	// ****************************************************************
	// per-line checks
	// ****************************************************************
	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_chk
			// edge and clear in one cycle: the edge wins
			a_set_wins: assert property ( // RL11
				(trig[g] && pend_clr[g]) |=> pend[g])
				else $error("clear beat a same-cycle edge");

			// a selected edge sets its own bit
			a_line_set: assert property ( // RL4
				trig[g] |=> pend[g])
				else $error("line edge did not set its pending bit");

			// each line's request depends on its own mask only
			a_irq_line: assert property ( // RL3
				##1 (irq_req[g] == (pend[g] && $past(irq_unmask[g]))))
				else $error("line request ignores its own mask");
		end
	endgenerate

	// ****************************************************************
	// scenarios worth seeing
	// ****************************************************************
	c_irq_raise: cover property (
		(|irq_req) ##1 (|pend_clr) ##1 !(|pend));
	c_sld_event: cover property (sld_en && trig[LINE_SLD]);
	c_set_clear: cover property (|(trig & pend_clr));
	c_wakeup: cover property (wakeup);
	c_evt_pulse: cover property ((|evt_req) ##1 !(|evt_req));

endmodule : ext_edge_event_ctrl
`default_nettype wire

// ### bench/source_model.sv
`timescale 1ns/1ps
`default_nettype none
module source_model (
	output logic [edge_event_pkg::NUM_PINS-1:0] pin_in,
	output logic                                sld_out,
	output logic                                rtc_alarm,
	output logic                                aux_event
);
	import edge_event_pkg::*;
	// pins, then supply detector, clock alarm, spare source
	logic [NUM_PINS+2:0] src = '0;
	// spread the source vector onto the outputs
	assign pin_in = src[NUM_PINS-1:0];
	assign {aux_event, rtc_alarm, sld_out} = src[NUM_PINS+2:NUM_PINS];
	// a 4 ns glitch, far narrower than one clock period
	task automatic pulse(input int idx);
		src[idx] = ~src[idx];
		#4;
		src[idx] = ~src[idx];
	endtask : pulse
	// a held level change
	task automatic drive(input int idx, input logic lvl);
		src[idx] = lvl;
	endtask : drive
endmodule : source_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import edge_event_pkg::*;
	logic                mclk = 1'b0;
	logic                rst_n = 1'b0;
	logic [NUM_PINS-1:0] pin_in;
	logic                sld_out, rtc_alarm, aux_event, wakeup, wk;
	logic                sld_en = 1'b0;
	port_sel_t           port_sel = '0;
	line_cfg_s           cfg = '0;
	line_vec_t           pend_clr = '0;
	line_vec_t           pend, irq_req, evt_req, ev;
	int                  num_errors = 0;
	int                  checks = 0;
	// 25 ns clock
	always #12.5 mclk = ~mclk;
	source_model u_source_model (.pin_in(pin_in), .sld_out(sld_out),
		.rtc_alarm(rtc_alarm), .aux_event(aux_event));
	ext_edge_event_ctrl u_ext_edge_event_ctrl (.mclk(mclk), .rst_n(rst_n),
		.pin_in(pin_in), .port_sel(port_sel), .sld_out(sld_out),
		.sld_en(sld_en), .rtc_alarm(rtc_alarm), .aux_event(aux_event),
		.cfg(cfg), .pend_clr(pend_clr), .pend(pend), .irq_req(irq_req),
		.evt_req(evt_req), .wakeup(wakeup));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic int src_of(input int ln);
		return (ln < NUM_EXT) ? (ln % NUM_PORTS) * NUM_EXT + ln
			: NUM_PINS + ln - NUM_EXT;
	endfunction : src_of
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : step
	// wait out the crossing, collecting event and wakeup pulses
	task automatic settle;
		ev = '0;
		wk = 1'b0;
		repeat (6) begin
			step(1);
			ev |= evt_req;
			wk |= wakeup;
		end
	endtask : settle
	task automatic clr;
		pend_clr = '1;
		step(1);
		pend_clr = '0;
		step(1);
	endtask : clr
	task automatic check(input line_vec_t seen, input line_vec_t exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// watchdog, far beyond the few hundred cycles needed
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (8) @(posedge mclk);
		#2 rst_n = 1'b1;
		for (int i = 0; i < NUM_EXT; i++)
			port_sel[i] = 3'(i % NUM_PORTS);
		cfg = '{rise_en: '1, fall_en: '0, irq_unmask: '1, evt_unmask: '1};
		sld_en = 1'b1;
		step(4);
		check(pend, '0);
		// glitch on every line, the pin lines through their selected port
		for (int i = 0; i < NUM_LINES; i++) begin
			u_source_model.pulse(src_of(i));
			settle();
			check(pend, line_vec_t'(1) << i);
			check(irq_req, line_vec_t'(1) << i);
			check(ev, line_vec_t'(1) << i);
			check(line_vec_t'(wk), line_vec_t'(1));
			clr();
			check(pend | irq_req, '0);
		end
		$display("test lines done");
		// every edge selection on line 5: step up, then down
		for (int k = 0; k < 4; k++) begin
			cfg.rise_en[5] = k[0];
			cfg.fall_en[5] = k[1];
			u_source_model.drive(src_of(5), 1'b1);
			settle();
			check(pend, line_vec_t'(k[0]) << 5);
			clr();
			u_source_model.drive(src_of(5), 1'b0);
			settle();
			check(pend, line_vec_t'(k[1]) << 5);
			clr();
		end
		cfg.rise_en[5] = 1'b1;
		$display("test edge kinds done");
		// line 3 masked, line 4 open
		cfg.irq_unmask[3] = 1'b0;
		cfg.evt_unmask[3] = 1'b0;
		u_source_model.pulse(src_of(3));
		u_source_model.pulse(src_of(4));
		settle();
		check(pend, line_vec_t'(5'h18));
		check(irq_req, line_vec_t'(5'h10));
		check(ev, line_vec_t'(5'h10));
		step(3);
		check(pend, line_vec_t'(5'h18));
		cfg.irq_unmask[3] = 1'b1;
		step(1);
		check(irq_req, line_vec_t'(5'h18));
		clr();
		$display("test mask done");
		// edge and clear in the same cycle: the edge wins
		u_source_model.pulse(src_of(6));
		step(3);
		pend_clr = '1;
		step(1);
		pend_clr = '0;
		check(pend, line_vec_t'(1) << 6);
		clr();
		// unused selector code picks no pin
		port_sel[2] = 3'h7;
		u_source_model.pulse(2);
		settle();
		check(pend, '0);
		port_sel[2] = 3'h2;
		$display("test clear race done");
		// supply detector line gated by its enable, falling only
		sld_en = 1'b0;
		u_source_model.pulse(src_of(LINE_SLD));
		settle();
		check(pend, '0);
		check(ev | line_vec_t'(wk), '0);
		sld_en = 1'b1;
		cfg.rise_en[LINE_SLD] = 1'b0;
		cfg.fall_en[LINE_SLD] = 1'b1;
		u_source_model.drive(src_of(LINE_SLD), 1'b1);
		settle();
		check(pend, '0);
		check(ev, '0);
		u_source_model.drive(src_of(LINE_SLD), 1'b0);
		settle();
		check(pend, line_vec_t'(1) << LINE_SLD);
		$display("test supply done");
		// reset in mid-run clears all, with no false edge after it
		rst_n = 1'b0;
		step(2);
		check(pend | irq_req, '0);
		rst_n = 1'b1;
		settle();
		check(pend | ev, '0);
		$display("test reset done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
